// file: drsc_pkg.sv
// Package with constants and carrier types for the reset source controller.
package drsc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // Oscillator cycles the pin is held low after a watchdog reset.
  localparam int unsigned WDOG_LOW_CYCLES = 512;
  // Clock period in ns (100 MHz).
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Least warm reset low width, in ns (3.2 us).
  localparam int unsigned WARM_RESET_LOW_WIDTH_NS = 3200;
  // Sensed pin must stay low this many cycles to count (rounded up).
  localparam int unsigned WARM_RESET_LOW_CYCLES =
    (WARM_RESET_LOW_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 10;

  // ----------------------------------------
  // Oscillator selection
  // ----------------------------------------
  localparam logic [1:0] OSC_SEL_INT1 = 2'h0;
  localparam logic [1:0] OSC_SEL_INT2 = 2'h1;
  localparam logic [1:0] OSC_SEL_XTAL = 2'h2;
  localparam logic [1:0] OSC_SEL_RESET = OSC_SEL_INT2;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic powerOnReset;
    logic brownoutMonitorReset;
    logic watchdogResetSource;
    logic nmiWatchdogResetSource;
    logic debuggerSystemReset;
    logic secureCodeResetSource;
    logic simulatedPinReset;
    logic simulatedCoreOnlyReset;
  } drsc_src_t;

  typedef struct packed {
    logic coreReset;
    logic periphReset;
    logic debugReset;
    logic ioHighZ;
  } drsc_dom_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN = 2'b01
  } drsc_state_t;

  typedef struct packed {
    logic pinSync1;
    logic pinSync2;
    logic [CNT_W-1:0] wdogCnt;
    logic [CNT_W-1:0] lowCnt;
    logic holdAll;
    logic holdDebug;
    drsc_state_t state;
    logic bootStart;
    logic [1:0] bootMode;
    logic [1:0] oscSel;
  } drsc_regs_t;

endpackage

// file: drsc_reset_source_control.sv
// Reset source combining and reset pin control.
`timescale 1ns/1ns

module drsc_reset_source_control #(
  parameter int unsigned WDOG_CYCLES = drsc_pkg::WDOG_LOW_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Reset sources
  input drsc_pkg::drsc_src_t resetSources,
  // Device reset pin, open drain
  input wire logic deviceResetPinIn_n,
  output logic deviceResetPinOut_n,
  output logic deviceResetPinOe,
  // Boot mode pins
  input wire logic [1:0] bootModePins,
  // Reset domains and boot control
  output drsc_pkg::drsc_dom_t resetDomains,
  output logic bootStart,
  output logic [1:0] bootMode,
  output logic [1:0] oscSel
);

  // Counter width, repeated here so the size casts read plainly.
  localparam int unsigned CNT_W = drsc_pkg::CNT_W;

  // ----------------------------------------
  // Source decode
  // ----------------------------------------
  drsc_pkg::drsc_regs_t stateReg;
  drsc_pkg::drsc_regs_t stateNext;
  logic wdogAny;
  logic pinPullSrc;
  logic powerSrc;
  logic anySrc;
  logic pinLowSeen;
  logic pinPull;
  logic inReset;

  assign wdogAny = resetSources.watchdogResetSource
                 | resetSources.nmiWatchdogResetSource;
  assign powerSrc = resetSources.powerOnReset
                  | resetSources.brownoutMonitorReset;
  // Debugger and secure-code resets are deliberately absent here.
  assign pinPullSrc = powerSrc | wdogAny
                    | resetSources.simulatedPinReset;
  assign anySrc = pinPullSrc | resetSources.debuggerSystemReset
                | resetSources.secureCodeResetSource
                | resetSources.simulatedCoreOnlyReset;
  assign pinPull = pinPullSrc | (stateReg.wdogCnt != '0);
  // A pulse shorter than the warm width is treated as noise.
  assign pinLowSeen = !stateReg.pinSync2
    && (stateReg.lowCnt >= CNT_W'(drsc_pkg::WARM_RESET_LOW_CYCLES - 1));
  // Core, peripheral and I/O domains stay in reset for as long as boot has not been started.
  assign inReset = stateReg.state == drsc_pkg::ST_RESET;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    stateNext = stateReg;
    stateNext.pinSync1 = deviceResetPinIn_n;
    stateNext.pinSync2 = stateReg.pinSync1;
    stateNext.bootStart = 1'b0;
    if (stateReg.pinSync2)
    begin
      stateNext.lowCnt = '0;
    end
    else if (!pinLowSeen)
    begin
      stateNext.lowCnt = stateReg.lowCnt + CNT_W'(1);
    end
    if (wdogAny)
    begin
      stateNext.wdogCnt = CNT_W'(WDOG_CYCLES - 1);
    end
    else if (stateReg.wdogCnt != '0)
    begin
      stateNext.wdogCnt = stateReg.wdogCnt - CNT_W'(1);
    end
    stateNext.holdDebug = powerSrc;
    stateNext.holdAll = anySrc || pinPull || pinLowSeen;
    unique case (stateReg.state)
      drsc_pkg::ST_RESET:
      begin
        stateNext.oscSel = drsc_pkg::OSC_SEL_RESET;
        // Leave only once the pin is sensed high and nothing holds it.
        if (!anySrc && !pinPull && stateReg.pinSync2
            && !stateReg.holdAll)
        begin
          stateNext.state = drsc_pkg::ST_RUN;
          stateNext.bootStart = 1'b1;
          stateNext.bootMode = bootModePins;
        end
      end
      drsc_pkg::ST_RUN:
      begin
        if (anySrc || pinLowSeen)
        begin
          stateNext.state = drsc_pkg::ST_RESET;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stateReg <= '{pinSync1: 1'b0, pinSync2: 1'b0, wdogCnt: '0,
                    lowCnt: '0, holdAll: 1'b1, holdDebug: 1'b1,
                    state: drsc_pkg::ST_RESET, bootStart: 1'b0,
                    bootMode: 2'h0, oscSel: drsc_pkg::OSC_SEL_RESET};
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Output data is always low; only the enable moves.
  assign deviceResetPinOut_n = 1'b0;
  assign deviceResetPinOe = sys_rst | pinPull;
  // Core, peripheral and I/O assertion is immediate on any source, debug only on power sources; release waits for the register.
  assign resetDomains.coreReset = sys_rst | anySrc | stateReg.holdAll
                                | inReset;
  assign resetDomains.periphReset = sys_rst | anySrc | stateReg.holdAll
                                  | inReset;
  assign resetDomains.ioHighZ = sys_rst | anySrc | stateReg.holdAll
                              | inReset;
  assign resetDomains.debugReset = sys_rst | powerSrc
                                 | stateReg.holdDebug;
  assign bootStart = stateReg.bootStart;
  assign bootMode = stateReg.bootMode;
  assign oscSel = stateReg.oscSel;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  pin_drive_low_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    deviceResetPinOut_n == 1'b0)
    else $error("Reset pin driven high.");

  power_pin_low_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    powerSrc |-> deviceResetPinOe)
    else $error("Power reset did not pull pin.");

  wdog_pin_low_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(wdogAny) |-> deviceResetPinOe [*8])
    else $error("Watchdog reset did not pull pin.");

  wdog_hold_cnt_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (wdogAny ##1 !wdogAny) |-> stateReg.wdogCnt == CNT_W'(WDOG_CYCLES - 1))
    else $error("Watchdog hold count wrong.");

  wdog_hold_end_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (stateReg.wdogCnt == CNT_W'(1) && !pinPullSrc)
      |=> stateReg.wdogCnt == '0 && (pinPullSrc || !deviceResetPinOe))
    else $error("Watchdog hold length wrong.");

  debug_untouched_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!powerSrc && !stateReg.holdDebug) |-> !resetDomains.debugReset)
    else $error("Debug reset by non-power source.");

  debug_power_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    powerSrc |-> resetDomains.debugReset)
    else $error("Power reset missed debug logic.");

  core_reset_all_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    anySrc |-> resetDomains.coreReset && resetDomains.ioHighZ)
    else $error("Source missed core reset.");

  no_pin_soft_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!pinPullSrc && stateReg.wdogCnt == '0) |-> !deviceResetPinOe)
    else $error("Pin pulled by a non-pin source.");

  boot_sample_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (stateReg.state == drsc_pkg::ST_RESET && stateNext.bootStart)
      |=> bootStart && bootMode == $past(bootModePins))
    else $error("Boot mode not sampled.");

  boot_pulse_one_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    bootStart |=> !bootStart)
    else $error("Boot pulse longer than one cycle.");

  osc_default_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    stateReg.state == drsc_pkg::ST_RESET
      |-> oscSel == drsc_pkg::OSC_SEL_INT2)
    else $error("Wrong oscillator in reset.");

  boot_wait_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    bootStart |-> $past(stateReg.pinSync2) && !$past(pinPull))
    else $error("Boot began while pin held.");

  core_hold_boot_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (stateReg.state == drsc_pkg::ST_RESET && !stateNext.bootStart)
      |-> resetDomains.coreReset && resetDomains.periphReset
          && resetDomains.ioHighZ)
    else $error("Domains released before boot.");

  pin_high_run_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (stateReg.state == drsc_pkg::ST_RUN && stateReg.pinSync2 && !anySrc)
      ##1 !anySrc |-> !resetDomains.coreReset)
    else $error("Core reset without a cause.");

endmodule // drsc_reset_source_control

// file: drsc_pin_partner.sv
// Model of the pull-up, the external supervisor and the boot strap drivers.
`timescale 1ns/1ns
module drsc_pin_partner (
  // Clock
  input wire logic clk,
  // Supervisor request and boot strap select
  input wire logic pullStart,
  input wire logic [9:0] pullCycles,
  input wire logic [1:0] bootSel,
  // Device pin side
  input wire logic pinOut_n,
  input wire logic pinOe,
  output logic pinLevel,
  output logic [1:0] bootModePins
);
  logic [9:0] pullCnt = 10'h000;

  // The supervisor only pulls low; the resistor gives the high level.
  assign pinLevel = !((pinOe && !pinOut_n) || (pullCnt != 10'h000));
  // Boot straps follow bootSel directly; the testbench changes them as each source reset is applied.
  assign bootModePins = bootSel;

  always @(posedge clk)
    if (pullStart)
      pullCnt <= pullCycles;
    else if (pullCnt != 10'h000)
      pullCnt <= pullCnt - 10'h001;
endmodule // drsc_pin_partner

// file: test_device_reset_source_control.sv
// Self-checking testbench for the reset source controller.
`timescale 1ns/1ns
module test_device_reset_source_control;
  localparam int unsigned WD = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  drsc_pkg::drsc_src_t resetSources = '0;
  logic pullStart = 1'b0;
  logic [9:0] pullCycles = 10'h000;
  logic [1:0] bootSel = 2'h2;
  logic pinLevel, pinOut_n, pinOe, bootStart;
  logic [1:0] bootModePins, bootMode, oscSel;
  drsc_pkg::drsc_dom_t resetDomains;
  int miscompares = 0;
  int n_compared = 0;
  int oeSeen = 0;

  always #5 clk = ~clk;

  drsc_reset_source_control #(.WDOG_CYCLES(WD)) i_drsc_reset_source_control (
    .clk(clk), .sys_rst(sys_rst), .resetSources(resetSources),
    .deviceResetPinIn_n(pinLevel), .deviceResetPinOut_n(pinOut_n),
    .deviceResetPinOe(pinOe), .bootModePins(bootModePins),
    .resetDomains(resetDomains), .bootStart(bootStart),
    .bootMode(bootMode), .oscSel(oscSel));

  drsc_pin_partner i_drsc_pin_partner (
    .clk(clk), .pullStart(pullStart), .pullCycles(pullCycles),
    .bootSel(bootSel), .pinOut_n(pinOut_n), .pinOe(pinOe),
    .pinLevel(pinLevel), .bootModePins(bootModePins));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Waits for the boot pulse, counting cycles with the pin pulled.
  task automatic wait_boot();
    int n;
    n = 0;
    while (bootStart !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (pinOe === 1'b1)
        oeSeen++;
      if (n > 2000)
      begin
        miscompares++;
        complete_run();
      end
    end
    check(8'(bootMode), 8'(bootSel));
    check(8'(pinLevel), 8'h01);
    check(8'(oscSel), 8'(drsc_pkg::OSC_SEL_INT2));
    @(posedge clk);
    #1;
    check(8'(resetDomains), 8'h00);
    check(8'(bootStart), 8'h00);
  endtask

  task automatic reset_test();
    @(posedge clk);
    #1;
    check(8'(pinOe), 8'h01);
    check(8'(oscSel), 8'(drsc_pkg::OSC_SEL_INT2));
    check(8'(pinOut_n), 8'h00);
    check(8'(resetDomains), 8'h0F);
    check(8'(bootStart), 8'h00);
    repeat (15) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    check(8'(resetDomains), 8'h0D);
    check(8'(pinOe), 8'h00);
    wait_boot();
  endtask

  task automatic source_test();
    logic [7:0] src;
    logic [7:0] want;
    for (int i = 0; i < 8; i++)
    begin
      src = 8'h80 >> i;
      @(posedge clk);
      resetSources <= src;
      bootSel <= 2'(i);
      #1;
      check(8'(pinOe), 8'(|(src & 8'hF2)));
      check(8'(resetDomains), {4'h0, 2'h3, |(src & 8'hC0), 1'b1});
      oeSeen = (pinOe === 1'b1) ? 1 : 0;
      @(posedge clk);
      resetSources <= '0;
      #1;
      if (pinOe === 1'b1)
        oeSeen++;
      wait_boot();
      want = (i == 2 || i == 3) ? 8'(WD) : 8'(|(src & 8'hF2));
      check(8'(oeSeen), want);
    end
  endtask

  task automatic ext_pin_test(input logic [9:0] len, input logic fires);
    @(posedge clk);
    pullCycles <= len;
    pullStart <= 1'b1;
    @(posedge clk);
    pullStart <= 1'b0;
    repeat (328) @(posedge clk);
    #1;
    check(8'(resetDomains.coreReset), 8'(fires));
    check(8'(pinOe), 8'h00);
    if (fires)
      wait_boot();
  endtask

  initial
  begin
    #1;
    reset_test();
    source_test();
    ext_pin_test(10'h12C, 1'b0);
    ext_pin_test(10'h14A, 1'b1);
    complete_run();
  end
endmodule // test_device_reset_source_control
